// File: pkg/sarr_pkg.sv
package sarr_pkg;

    // ------------------------------------------------------------
    // Clock and serial rate
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned SCLK_MAX_HZ = 200_000;
    // Least half period, rounded up so the link never beats the limit
    localparam int unsigned SCLK_HALF_CYC = (CLK_HZ + 2 * SCLK_MAX_HZ - 1) / (2 * SCLK_MAX_HZ);

    // ------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------
    localparam int unsigned BYTE_W = 8;
    localparam int unsigned RESULT_W = 12;
    localparam int unsigned FRAME_BYTES = 3;
    localparam int unsigned OUT_BITS = 16;
    localparam int unsigned PAD_HI_W = 3;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [4:0] OUT_LAST = 5'h0F;
    localparam logic [1:0] BYTE_CFG = 2'h0;
    localparam logic [1:0] BYTE_HI = 2'h1;
    localparam logic [1:0] BYTE_LO = 2'h2;
    localparam logic [7:0] HI_MASK = 8'h1F;
    localparam logic [7:0] LO_MASK = 8'hFE;
    localparam logic [7:0] CFG_CH0_SE = 8'h08;
    localparam logic [7:0] FILL_BYTE = 8'h00;

    // Pin order in the device synchroniser vector
    localparam int unsigned PIN_CS = 2;
    localparam int unsigned PIN_SCLK = 1;
    localparam int unsigned PIN_MOSI = 0;

endpackage

// File: pkg/sarr_link_if.sv
`timescale 1ns/1ps
interface sarr_link_if;
    logic cs;
    logic sclk;
    logic mosi;
    logic miso;
    modport host (output cs, output sclk, output mosi, input miso);
    modport adc (input cs, input sclk, input mosi, output miso);
endinterface

// File: src/sarr_adc.sv
`timescale 1ns/1ps
module sarr_adc
    import sarr_pkg::*;
(
    input wire logic clk_sys, // System clock
    input wire logic sys_rst, // Synchronous reset, high
    sarr_link_if.adc link, // Four-wire link
    input wire logic [RESULT_W-1:0] sample_result, // Converted value
    output logic [BYTE_W-1:0] config_word, // Last received config byte
    output logic config_valid, // Pulse: config byte received
    output logic ch0_single_ended, // Config selects channel 0 vs ground
    output logic sample_taken, // Pulse: result captured
    output logic frame_done // Pulse: all result bits sent
);

    typedef enum logic [1:0] {ST_IDLE, ST_CFG, ST_SEND} sarr_adc_state_type;

    // ------------------------------------------------------------
    // Pin synchronisers and edge finding
    // ------------------------------------------------------------
    logic [2:0] pin_s1;
    logic [2:0] pin_s2;
    logic [2:0] pin_s3;
    sarr_adc_state_type state;
    logic [4:0] bit_cnt;
    logic [BYTE_W-1:0] cfg_shift;
    logic [OUT_BITS-1:0] out_shift;

    wire cs_rise = pin_s2[PIN_CS] & ~pin_s3[PIN_CS];
    wire cs_fall = ~pin_s2[PIN_CS] & pin_s3[PIN_CS];
    wire sclk_rise = pin_s2[PIN_SCLK] & ~pin_s3[PIN_SCLK];
    wire sclk_fall = ~pin_s2[PIN_SCLK] & pin_s3[PIN_SCLK];
    wire [BYTE_W-1:0] cfg_next = {cfg_shift[BYTE_W-2:0], pin_s2[PIN_MOSI]};
    wire cfg_last = (bit_cnt[2:0] == BIT_LAST);
    wire out_last = (bit_cnt == OUT_LAST);
    // Pads, then bits 11..7, then bits 6..0, then one pad
    wire [OUT_BITS-1:0] out_load = {{PAD_HI_W{1'b0}}, sample_result, 1'b0};

    // Result pin straight from the shifter, most significant first
    assign link.miso = out_shift[OUT_BITS-1];

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pin_s1 <= 3'h0;
            pin_s2 <= 3'h0;
            pin_s3 <= 3'h0;
        end else begin
            pin_s1 <= {link.cs, link.sclk, link.mosi};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    // ------------------------------------------------------------
    // Frame engine
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state <= ST_IDLE;
            bit_cnt <= 5'h00;
            cfg_shift <= 8'h00;
            out_shift <= 16'h0000;
            config_word <= 8'h00;
            config_valid <= 1'b0;
            ch0_single_ended <= 1'b0;
            sample_taken <= 1'b0;
            frame_done <= 1'b0;
        end else begin
            config_valid <= 1'b0;
            sample_taken <= 1'b0;
            frame_done <= 1'b0;
            if (cs_rise) begin
                // Select high opens a new cycle, even mid-frame
                state <= ST_CFG;
                bit_cnt <= 5'h00;
                out_shift <= 16'h0000;
            end else if (cs_fall) begin
                state <= ST_SEND;
                bit_cnt <= 5'h00;
                out_shift <= out_load;
                sample_taken <= 1'b1;
            end else begin
                unique case (state)
                    ST_IDLE: begin
                    end
                    ST_CFG: begin
                        if (sclk_rise) begin
                            cfg_shift <= cfg_next;
                            bit_cnt <= bit_cnt + 5'h01;
                            if (cfg_last) begin
                                config_word <= cfg_next;
                                config_valid <= 1'b1;
                                ch0_single_ended <= (cfg_next == CFG_CH0_SE);
                                state <= ST_IDLE;
                            end
                        end
                    end
                    ST_SEND: begin
                        // Mode 0: change on falling, host samples at end of high half
                        if (sclk_fall) begin
                            out_shift <= {out_shift[OUT_BITS-2:0], 1'b0};
                        end
                        if (sclk_rise) begin
                            bit_cnt <= bit_cnt + 5'h01;
                            if (out_last) begin
                                frame_done <= 1'b1;
                                state <= ST_IDLE;
                            end
                        end
                    end
                endcase
            end
        end
    end

endmodule

// File: src/sarr_host.sv
`timescale 1ns/1ps
module sarr_host
    import sarr_pkg::*;
#(
    parameter int unsigned HALF_CYC = SCLK_HALF_CYC
) (
    input wire logic clk_sys, // System clock
    input wire logic sys_rst, // Synchronous reset, high
    sarr_link_if.host link, // Four-wire link
    input wire logic start, // Pulse: begin one conversion
    input wire logic [BYTE_W-1:0] config_byte, // Config byte to send
    output logic busy, // Exchange in progress
    output logic [RESULT_W-1:0] result, // Right-justified result
    output logic result_valid // Pulse: result updated
);

    typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH, ST_GAP} sarr_host_state_type;

    localparam int unsigned TICK_W = (HALF_CYC > 1) ? $clog2(HALF_CYC) : 1;
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(HALF_CYC - 1);
    localparam logic [TICK_W-1:0] TICK_ZERO = '0;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    sarr_host_state_type state;
    sarr_host_state_type next_state;
    logic [TICK_W-1:0] tick_cnt;
    logic [2:0] bit_cnt;
    logic [1:0] byte_idx;
    logic [BYTE_W-1:0] tx_shift;
    logic [BYTE_W-1:0] rx_shift;
    logic [BYTE_W-1:0] byte_hi;
    logic cs;
    logic sclk;
    logic mosi;
    logic miso_s1;
    logic miso_s2;

    // ------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------
    wire tick_done = (tick_cnt == TICK_LAST);
    wire bit_last = (bit_cnt == BIT_LAST);
    wire in_idle = (state == ST_IDLE);
    wire go = in_idle & start;
    wire rise_now = (state == ST_LOW) & tick_done;
    wire fall_now = (state == ST_HIGH) & tick_done;
    wire byte_end = fall_now & bit_last;
    wire gap_end = (state == ST_GAP) & tick_done;
    wire frame_end = gap_end & (byte_idx == BYTE_LO);
    wire next_byte = gap_end & (byte_idx != BYTE_LO);
    wire [BYTE_W-1:0] rx_next = {rx_shift[BYTE_W-2:0], miso_s2};
    wire [BYTE_W-1:0] tx_next = {tx_shift[BYTE_W-2:0], 1'b0};
    // Mask pads of both result bytes, then drop the trailing pad
    wire [OUT_BITS-1:0] joined = {byte_hi & HI_MASK, rx_shift & LO_MASK};
    wire [RESULT_W-1:0] right_just = joined[RESULT_W:1];

    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (start) begin
                    next_state = ST_LOW;
                end
            end
            ST_LOW: begin
                if (tick_done) begin
                    next_state = ST_HIGH;
                end
            end
            ST_HIGH: begin
                if (tick_done) begin
                    next_state = bit_last ? ST_GAP : ST_LOW;
                end
            end
            ST_GAP: begin
                if (tick_done) begin
                    next_state = (byte_idx == BYTE_LO) ? ST_IDLE : ST_LOW;
                end
            end
        endcase
    end

    assign link.cs = cs;
    assign link.sclk = sclk;
    assign link.mosi = mosi;

    // ------------------------------------------------------------
    // Result pin synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            miso_s1 <= 1'b0;
            miso_s2 <= 1'b0;
        end else begin
            miso_s1 <= link.miso;
            miso_s2 <= miso_s1;
        end
    end

    // ------------------------------------------------------------
    // Sequencing and half-period timer
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state <= ST_IDLE;
            tick_cnt <= TICK_ZERO;
        end else begin
            state <= next_state;
            // Every non-idle step lasts one half period
            if (in_idle || tick_done) begin
                tick_cnt <= TICK_ZERO;
            end else begin
                tick_cnt <= tick_cnt + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Link pins and shifters
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cs <= 1'b0;
            sclk <= 1'b0;
            mosi <= 1'b0;
            bit_cnt <= 3'h0;
            byte_idx <= BYTE_CFG;
            tx_shift <= 8'h00;
            rx_shift <= 8'h00;
        end else begin
            if (go) begin
                // Config bit set up a full half period before the first rise
                cs <= 1'b1;
                tx_shift <= config_byte;
                mosi <= config_byte[BYTE_W-1];
                byte_idx <= BYTE_CFG;
                bit_cnt <= 3'h0;
            end
            if (rise_now) begin
                sclk <= 1'b1;
            end
            if (fall_now) begin
                // Sample at end of high half; covers sync and device lag
                sclk <= 1'b0;
                rx_shift <= rx_next;
                bit_cnt <= bit_cnt + 3'h1;
                if (!bit_last) begin
                    tx_shift <= tx_next;
                    mosi <= tx_shift[BYTE_W-2];
                end
            end
            if (gap_end && byte_idx == BYTE_CFG) begin
                cs <= 1'b0;
            end
            if (next_byte) begin
                // Result bytes carry no command; fill is sent
                byte_idx <= byte_idx + 2'h1;
                tx_shift <= FILL_BYTE;
                mosi <= FILL_BYTE[BYTE_W-1];
            end
        end
    end

    // ------------------------------------------------------------
    // Result assembly
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            byte_hi <= 8'h00;
            result <= 12'h000;
            result_valid <= 1'b0;
            busy <= 1'b0;
        end else begin
            result_valid <= 1'b0;
            if (go) begin
                busy <= 1'b1;
            end
            if (byte_end && byte_idx == BYTE_HI) begin
                // Last bit lands on this same edge
                byte_hi <= rx_next;
            end
            if (frame_end) begin
                // Third byte is complete in rx_shift by now
                result <= right_just;
                result_valid <= 1'b1;
                busy <= 1'b0;
            end
        end
    end

endmodule

// File: test/sarr_link_monitor.sv
`timescale 1ns/1ps
module sarr_link_monitor (
    input wire logic clk_sys, // System clock
    input wire logic sys_rst, // Sync reset, high
    input wire logic cs, // Chip select
    input wire logic sclk, // Serial clock
    input wire logic mosi, // Config data
    input wire logic miso // Result data
);
    logic prev_sclk;
    logic prev_cs;
    logic seen;
    logic [4:0] cfg_cnt;
    logic [4:0] res_cnt;
    wire logic sclk_rise = sclk && !prev_sclk;
    wire logic cs_rise = cs && !prev_cs;
    wire logic [4:0] next_cfg = cs_rise ? 5'h00 : cfg_cnt + 5'(cs && sclk_rise);
    wire logic [4:0] next_res = cs_rise ? 5'h00 : res_cnt + 5'(!cs && sclk_rise);
    always_ff @(posedge clk_sys) begin
        prev_sclk <= sys_rst ? 1'b0 : sclk;
        prev_cs <= sys_rst ? 1'b0 : cs;
        seen <= sys_rst ? 1'b0 : (seen || (prev_cs && !cs));
        cfg_cnt <= sys_rst ? 5'h00 : next_cfg;
        res_cnt <= sys_rst ? 5'h00 : next_res;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // Four cycles is the bench half period; longer levels also pass
    sequence s_hold_high;
        sclk [*4];
    endsequence
    sequence s_hold_low;
        !sclk [*4];
    endsequence
    a_sclk_high_len: assert property ($rose(sclk) |-> s_hold_high)
        else $error("serial clock high level too short");
    a_sclk_low_len: assert property ($fell(sclk) |-> s_hold_low)
        else $error("serial clock low level too short");
    a_cs_clock_idle: assert property ($changed(cs) |-> !sclk && !$past(sclk))
        else $error("select changed while serial clock high");
    a_mosi_hold_high: assert property (sclk && $past(sclk) |-> $stable(mosi))
        else $error("config data moved while clock high");
    a_miso_hold_high: assert property (sclk && $past(sclk) |-> $stable(miso))
        else $error("result data moved while clock high");
    a_miso_quiet_cfg: assert property (cs && $past(cs, 4) |-> !miso)
        else $error("result line active in config phase");
    a_mosi_fill_zero: assert property (!cs && sclk |-> !mosi)
        else $error("config line active in result phase");
    a_cfg_bit_count: assert property ($fell(cs) |-> cfg_cnt == 5'h08)
        else $error("config byte not eight clocks");
    a_res_bit_count: assert property ($rose(cs) |-> (res_cnt == 5'h10 || !seen))
        else $error("result phase not sixteen clocks");
endmodule

// File: test/serial_adc_result_readout_tb.sv
`timescale 1ns/1ps
module serial_adc_result_readout_tb;
    import sarr_pkg::*;
    localparam int unsigned H = 4;
    localparam int unsigned LAT = 51 * H;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic start = 1'b0;
    logic [7:0] config_byte = 8'h00;
    logic [11:0] sample_result = 12'h000;
    logic busy, result_valid, config_valid, ch0_single_ended, sample_taken, frame_done;
    logic [11:0] result;
    logic [7:0] config_word;
    logic prev_sclk = 1'b0;
    logic [7:0] cfg_bits = 8'h00;
    logic [15:0] res_bits = 16'h0000;
    int n_mismatch = 0;
    int checks = 0;
    int cycles = 0;
    int n_cfgv = 0;
    int n_take = 0;
    int n_done = 0;
    sarr_link_if link ();
    sarr_host #(.HALF_CYC(H)) u_sarr_host (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(link),
        .start(start), .config_byte(config_byte), .busy(busy), .result(result),
        .result_valid(result_valid));
    sarr_adc u_sarr_adc (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(link),
        .sample_result(sample_result), .config_word(config_word), .config_valid(config_valid),
        .ch0_single_ended(ch0_single_ended), .sample_taken(sample_taken),
        .frame_done(frame_done));
    sarr_link_monitor u_sarr_link_monitor (.clk_sys(clk_sys), .sys_rst(sys_rst), .cs(link.cs),
        .sclk(link.sclk), .mosi(link.mosi), .miso(link.miso));
    always #50 clk_sys = ~clk_sys;
    // Wire bits are taken where the clock is first seen high
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        prev_sclk <= link.sclk;
        if (config_valid === 1'b1) n_cfgv <= n_cfgv + 1;
        if (sample_taken === 1'b1) n_take <= n_take + 1;
        if (frame_done === 1'b1) n_done <= n_done + 1;
        if (link.sclk === 1'b1 && prev_sclk === 1'b0) begin
            if (link.cs === 1'b1) cfg_bits <= {cfg_bits[6:0], link.mosi};
            else res_bits <= {res_bits[14:0], link.miso};
        end
        if (cycles == 5000) begin
            n_mismatch = n_mismatch + 1;
            report_and_stop();
        end
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic run_frame(input logic [7:0] cfg, input logic [11:0] smp, input bit settle,
        input bit poke);
        int n;
        int b_cfgv;
        int b_take;
        int b_done;
        b_cfgv = n_cfgv;
        b_take = n_take;
        b_done = n_done;
        config_byte = cfg;
        sample_result = smp;
        start = 1'b1;
        @(posedge clk_sys);
        #1;
        start = 1'b0;
        n = 0;
        while (result_valid !== 1'b1 && n < 400) begin
            @(posedge clk_sys);
            #1;
            n++;
            start = (poke && n == 60);
            if (poke) config_byte = ~cfg;
        end
        chk("latency", 16'(LAT), 16'(n));
        chk("result", {4'h0, smp}, {4'h0, result});
        chk("busy", 16'h0000, {15'h0000, busy});
        chk("config on wire", {8'h00, cfg}, {8'h00, cfg_bits});
        chk("result on wire", {3'h0, smp, 1'b0}, res_bits);
        chk("config word", {8'h00, cfg}, {8'h00, config_word});
        chk("channel zero", {15'h0000, cfg === CFG_CH0_SE}, {15'h0000, ch0_single_ended});
        if (settle) begin
            repeat (6) @(posedge clk_sys);
            #1;
            chk("config pulses", 16'h0001, 16'(n_cfgv - b_cfgv));
            chk("sample pulses", 16'h0001, 16'(n_take - b_take));
            chk("done pulses", 16'h0001, 16'(n_done - b_done));
        end
    endtask
    task automatic t_reset_state();
        chk("idle pins", 16'h0000, {13'h0000, link.cs, link.sclk, link.mosi});
        chk("idle result", 16'h0000, {3'h0, busy, result});
        chk("idle config", 16'h0000, {7'h00, ch0_single_ended, config_word});
    endtask
    task automatic t_channel_codes();
        run_frame(CFG_CH0_SE, 12'hFFF, 1'b1, 1'b0);
        run_frame(8'h0C, 12'h000, 1'b1, 1'b0);
        run_frame(8'hF7, 12'hA5A, 1'b1, 1'b0);
    endtask
    task automatic t_boundary_bits();
        run_frame(CFG_CH0_SE, 12'h080, 1'b1, 1'b0);
        run_frame(CFG_CH0_SE, 12'h07F, 1'b1, 1'b0);
        run_frame(8'h80, 12'h801, 1'b1, 1'b0);
    endtask
    task automatic t_back_to_back();
        run_frame(8'h0C, 12'h5A5, 1'b0, 1'b0);
        run_frame(CFG_CH0_SE, 12'hC3C, 1'b1, 1'b0);
    endtask
    task automatic t_busy_refuse();
        run_frame(8'h01, 12'h3C3, 1'b1, 1'b1);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk_sys);
        #1;
        sys_rst = 1'b0;
        repeat (4) @(posedge clk_sys);
        #1;
        t_reset_state();
        t_channel_codes();
        t_boundary_bits();
        t_back_to_back();
        t_busy_refuse();
        report_and_stop();
    end
endmodule
